// ==== design/port_ab_alt_function_override.sv ====
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pin_alt_defines.svh"

// What this block does
// - Each port A pin is the pin-change source with its own index 0 to 7.
// - Port A: no pull, direction or value override; input kept on when sensed.
// - Port A pads go straight to converter channels; inputs feed pin-change lines.
// - Port B bit 7 is serial clock; forced input as slave, own direction as master.
// - A serial pin forced to input keeps its pull-up under its port output bit.
// - Port B bit 6 is master-in data; forced input as master, own direction as slave.
// - Port B bit 5 is master-out data; forced input as slave, own direction as master.
// - Port B bit 4 is slave select, forced input as slave, slave active while low.
// - Port B pins 7 to 2 feed pin-change sources 15 to 10.
// - Port B bit 2 also feeds external interrupt two.
// - Port B bits 3 and 2 reach comparator negative and positive inputs ungated.
// - Pull-up on for direction, out, disable 0,1,0 unless override enable decides.
// - Driver follows direction override value when enabled, else direction bit.
// - Input buffer follows override value when enabled, else sleep clamps it.
module port_ab_alt_function_override #(
   parameter int ADR_W = 8
) (
   input  wire  logic                    clk_i,
   input  wire  logic                    rst_i,
   input  wire  logic                    wb_cyc_i,
   input  wire  logic                    wb_stb_i,
   input  wire  logic                    wb_we_i,
   input  wire  logic [ADR_W-1:0]        wb_adr_i,
   input  wire  logic [3:0]              wb_sel_i,
   input  wire  logic [31:0]             wb_dat_i,
   output logic       [31:0]             wb_dat_o,
   output logic                          wb_ack_o,
   output logic                          irq_o,
   input  wire  logic                    sleep_i,
   input  wire  pin_alt_pkg::spi_t       spi_i,
   input  wire  pin_alt_pkg::timer0_t    timer0_i,
   input  wire  logic                    ext_irq_two_en_i,
   input  wire  logic [7:0]              pad_a_i,
   input  wire  logic [7:2]              pad_b_i,
   output pin_alt_pkg::pad_ctl_t [7:0]   pad_a_o,
   output pin_alt_pkg::pad_ctl_t [7:2]   pad_b_o,
   output logic       [7:0]              adc_ch_o,
   output logic                          comparator_neg_in_o,
   output logic                          comparator_pos_in_o,
   output logic       [7:0]              pin_change_src_low_o,
   output logic       [15:10]            pin_change_src_high_o,
   output logic                          ext_irq_two_o,
   output logic                          spi_sck_in_o,
   output logic                          spi_master_in_o,
   output logic                          spi_slave_in_o,
   output logic                          spi_ss_n_o
);
   import pin_alt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check

   if (ADR_W < 6) begin : g_bad_adr
      $error("ADR_W must cover the register map");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic [2:0]  ctrl_reg;
   logic [7:0]  pa_dir_reg;
   logic [7:0]  pa_out_reg;
   logic [7:0]  pb_dir_reg;
   logic [7:0]  pb_out_reg;
   logic [7:0]  pc_mask_a_reg;
   logic [7:0]  pc_mask_b_reg;
   logic [7:0]  adc_didis_reg;
   logic [15:0] irq_stat_reg;
   logic [15:0] irq_mask_reg;
   logic [15:0] prev_reg;
   logic        prime_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        irq_reg;

   logic [15:0] irq_stat_next;
   logic [31:0] dat_next;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr == ofs);
   endfunction : hit

   // Sized cast serves any ADR_W from 6 up; upper bits ignored
   wire [7:0] adr8    = 8'(wb_adr_i);
   wire       req     = wb_cyc_i && wb_stb_i && !ack_reg;
   wire       wr_lo   = req && wb_we_i && wb_sel_i[0];
   wire       wr_hi   = req && wb_we_i && wb_sel_i[1];
   wire       sel_ctl = hit(adr8, `OFS_CTRL);
   wire       sel_pad = hit(adr8, `OFS_PA_DIR);
   wire       sel_pao = hit(adr8, `OFS_PA_OUT);
   wire       sel_pbd = hit(adr8, `OFS_PB_DIR);
   wire       sel_pbo = hit(adr8, `OFS_PB_OUT);
   wire       sel_pma = hit(adr8, `OFS_PC_MASK_A);
   wire       sel_pmb = hit(adr8, `OFS_PC_MASK_B);
   wire       sel_did = hit(adr8, `OFS_ADC_DIDIS);
   wire       sel_pai = hit(adr8, `OFS_PA_IN);
   wire       sel_pbi = hit(adr8, `OFS_PB_IN);
   wire       sel_ist = hit(adr8, `OFS_IRQ_STAT);
   wire       sel_imk = hit(adr8, `OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Control fields

   wire g0_en = ctrl_reg[`CTRL_G0_EN_BIT];
   wire g1_en = ctrl_reg[`CTRL_G1_EN_BIT];
   wire global_pullup_disable   = ctrl_reg[`CTRL_PUD_BIT];

   // Serial role terms
   wire spi_slave  = spi_i.en && !spi_i.master;
   wire spi_master = spi_i.en && spi_i.master;

   ////////////////////////////////////////////////////////////////////////////
   // Port A overrides and pads

   wire [7:0] pa_sense = pc_mask_a_reg & {8{g0_en}};
   wire [7:0] pa_digin;
   ovr_t      ovr_a [7:0];

   for (genvar i = 0; i < 8; i++) begin : g_pa
      assign ovr_a[i] = '{
         pullup_ovr_en:  1'b0,
         pullup_ovr_val: 1'b0,
         dir_ovr_en:     1'b0,
         dir_ovr_val:    1'b0,
         outval_ovr_en:  1'b0,
         outval_ovr_val: 1'b0,
         digin_ovr_en:   pa_sense[i] | adc_didis_reg[i],
         digin_ovr_val:  pa_sense[i]
      };

      pin_ovr_cell u_cell (
         .ovr_i   (ovr_a[i]),
         .cfg_i   ('{dir: pa_dir_reg[i], out: pa_out_reg[i]}),
         .pud_i   (global_pullup_disable),
         .sleep_i (sleep_i),
         .pad_i   (pad_a_i[i]),
         .pad_o   (pad_a_o[i]),
         .digin_o (pa_digin[i])
      );
   end

   // Analog path is the pad itself
   assign adc_ch_o             = pad_a_i;
   assign pin_change_src_low_o = pa_digin;

   ////////////////////////////////////////////////////////////////////////////
   // Port B overrides and pads

   wire [7:2] pb_sense = pc_mask_b_reg[7:2] & {6{g1_en}};
   wire [7:2] pb_digin;
   ovr_t      ovr_b [7:2];

   // Clock pin: input as slave, clock value as master once direction is set
   assign ovr_b[7] = '{
      pullup_ovr_en:  spi_slave,
      pullup_ovr_val: pb_out_reg[7] && !global_pullup_disable,
      dir_ovr_en:     spi_slave,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  spi_master,
      outval_ovr_val: spi_i.sck_out,
      digin_ovr_en:   pb_sense[7],
      digin_ovr_val:  1'b1
   };

   // Master-in pin: input as master, slave data out as slave
   assign ovr_b[6] = '{
      pullup_ovr_en:  spi_master,
      pullup_ovr_val: pb_out_reg[6] && !global_pullup_disable,
      dir_ovr_en:     spi_master,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  spi_slave,
      outval_ovr_val: spi_i.slave_out,
      digin_ovr_en:   pb_sense[6],
      digin_ovr_val:  1'b1
   };

   assign ovr_b[5] = '{
      pullup_ovr_en:  spi_slave,
      pullup_ovr_val: pb_out_reg[5] && !global_pullup_disable,
      dir_ovr_en:     spi_slave,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  spi_master,
      outval_ovr_val: spi_i.mstr_out,
      digin_ovr_en:   pb_sense[5],
      digin_ovr_val:  1'b1
   };

   // Select pin shares the compare B output
   assign ovr_b[4] = '{
      pullup_ovr_en:  spi_slave,
      pullup_ovr_val: pb_out_reg[4] && !global_pullup_disable,
      dir_ovr_en:     spi_slave,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  timer0_i.cmp_b_en,
      outval_ovr_val: timer0_i.cmp_b_out,
      digin_ovr_en:   pb_sense[4],
      digin_ovr_val:  1'b1
   };

   // Compare A value only reaches the pad once direction is set
   assign ovr_b[3] = '{
      pullup_ovr_en:  1'b0,
      pullup_ovr_val: 1'b0,
      dir_ovr_en:     1'b0,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  timer0_i.cmp_a_en,
      outval_ovr_val: timer0_i.cmp_a_out,
      digin_ovr_en:   pb_sense[3],
      digin_ovr_val:  1'b1
   };

   // Enabled external interrupt keeps the input alive in sleep
   assign ovr_b[2] = '{
      pullup_ovr_en:  1'b0,
      pullup_ovr_val: 1'b0,
      dir_ovr_en:     1'b0,
      dir_ovr_val:    1'b0,
      outval_ovr_en:  1'b0,
      outval_ovr_val: 1'b0,
      digin_ovr_en:   ext_irq_two_en_i | pb_sense[2],
      digin_ovr_val:  1'b1
   };

   for (genvar j = 2; j < 8; j++) begin : g_pb
      pin_ovr_cell u_cell (
         .ovr_i   (ovr_b[j]),
         .cfg_i   ('{dir: pb_dir_reg[j], out: pb_out_reg[j]}),
         .pud_i   (global_pullup_disable),
         .sleep_i (sleep_i),
         .pad_i   (pad_b_i[j]),
         .pad_o   (pad_b_o[j]),
         .digin_o (pb_digin[j])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port B inputs to peripherals

   assign pin_change_src_high_o = pb_digin;
   assign ext_irq_two_o         = pb_digin[2];
   assign spi_sck_in_o          = pb_digin[7];
   assign spi_master_in_o       = pb_digin[6];
   assign spi_slave_in_o        = pb_digin[5];
   // Pin level through the input buffer, low selects the slave
   assign spi_ss_n_o            = pb_digin[4];
   // No gating: comparator sees the pad even with input clamped
   assign comparator_neg_in_o   = pad_b_i[3];
   assign comparator_pos_in_o   = pad_b_i[2];

   ////////////////////////////////////////////////////////////////////////////
   // Pin-change events

   wire [15:0] src_all = {pb_digin, 2'b00, pa_digin};
   wire [15:0] evt_en  = {pb_sense, 2'b00, pa_sense};
   // Prime stops a false event from reset-time history
   wire [15:0] evt     = evt_en & (src_all ^ prev_reg) & {16{prime_reg}};
   wire [15:0] w1c     = {(wr_hi && sel_ist) ? wb_dat_i[15:8] : 8'h00,
                          (wr_lo && sel_ist) ? wb_dat_i[7:0]  : 8'h00};

   // Set wins over a clear in the same cycle
   assign irq_stat_next = (irq_stat_reg & ~w1c) | evt;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      dat_next = 32'h0000_0000;
      unique case (1'b1)
         sel_ctl: dat_next[2:0]  = ctrl_reg;
         sel_pad: dat_next[7:0]  = pa_dir_reg;
         sel_pao: dat_next[7:0]  = pa_out_reg;
         sel_pbd: dat_next[7:0]  = pb_dir_reg;
         sel_pbo: dat_next[7:0]  = pb_out_reg;
         sel_pma: dat_next[7:0]  = pc_mask_a_reg;
         sel_pmb: dat_next[7:0]  = pc_mask_b_reg;
         sel_did: dat_next[7:0]  = adc_didis_reg;
         sel_pai: dat_next[7:0]  = pa_digin;
         sel_pbi: dat_next[7:0]  = {pb_digin, 2'b00};
         sel_ist: dat_next[15:0] = irq_stat_reg;
         sel_imk: dat_next[15:0] = irq_mask_reg;
         default: dat_next       = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake, one wait state, unmapped reads zero

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req;
         dat_reg <= (req && !wb_we_i) ? dat_next : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg      <= `RST_CTRL;
         pa_dir_reg    <= `RST_BYTE;
         pa_out_reg    <= `RST_BYTE;
         pb_dir_reg    <= `RST_BYTE;
         pb_out_reg    <= `RST_BYTE;
         pc_mask_a_reg <= `RST_BYTE;
         pc_mask_b_reg <= `RST_BYTE;
         adc_didis_reg <= `RST_BYTE;
      end else if (wr_lo) begin
         if (sel_ctl) ctrl_reg      <= wb_dat_i[2:0];
         if (sel_pad) pa_dir_reg    <= wb_dat_i[7:0];
         if (sel_pao) pa_out_reg    <= wb_dat_i[7:0];
         if (sel_pbd) pb_dir_reg    <= wb_dat_i[7:0];
         if (sel_pbo) pb_out_reg    <= wb_dat_i[7:0];
         if (sel_pma) pc_mask_a_reg <= wb_dat_i[7:0];
         if (sel_pmb) pc_mask_b_reg <= wb_dat_i[7:0];
         if (sel_did) adc_didis_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= `RST_IRQ;
      end else begin
         if (wr_lo && sel_imk) irq_mask_reg[7:0]  <= wb_dat_i[7:0];
         if (wr_hi && sel_imk) irq_mask_reg[15:8] <= wb_dat_i[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status and interrupt line

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= `RST_IRQ;
         prev_reg     <= `RST_IRQ;
         prime_reg    <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         prev_reg     <= src_all;
         prime_reg    <= 1'b1;
         irq_reg      <= |(irq_stat_next & irq_mask_reg);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_o    = irq_reg;

endmodule : port_ab_alt_function_override

// ==== design/pin_alt_defines.svh ====
`ifndef PIN_ALT_DEFINES_SVH
`define PIN_ALT_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_PA_DIR    8'h04
`define OFS_PA_OUT    8'h08
`define OFS_PB_DIR    8'h0C
`define OFS_PB_OUT    8'h10
`define OFS_PC_MASK_A 8'h14
`define OFS_PC_MASK_B 8'h18
`define OFS_ADC_DIDIS 8'h1C
`define OFS_PA_IN     8'h20
`define OFS_PB_IN     8'h24
`define OFS_IRQ_STAT  8'h28
`define OFS_IRQ_MASK  8'h2C

// Control register fields
`define CTRL_G0_EN_BIT  0
`define CTRL_G1_EN_BIT  1
`define CTRL_PUD_BIT    2

// Reset values
`define RST_BYTE      8'h00
`define RST_CTRL      3'h0
`define RST_IRQ       16'h0000

`endif

// ==== design/pin_alt_pkg.sv ====
package pin_alt_pkg;

   // Override set feeding one pad
   typedef struct packed {
      logic pullup_ovr_en;
      logic pullup_ovr_val;
      logic dir_ovr_en;
      logic dir_ovr_val;
      logic outval_ovr_en;
      logic outval_ovr_val;
      logic digin_ovr_en;
      logic digin_ovr_val;
   } ovr_t;

   // Port register bits of one pin
   typedef struct packed {
      logic dir;
      logic out;
   } pin_cfg_t;

   // Drive towards one pad; drive_n low while driving
   typedef struct packed {
      logic drive_n;
      logic drive_val;
      logic pullup_en;
   } pad_ctl_t;

   typedef struct packed {
      logic en;
      logic master;
      logic sck_out;
      logic slave_out;
      logic mstr_out;
   } spi_t;

   typedef struct packed {
      logic cmp_a_en;
      logic cmp_a_out;
      logic cmp_b_en;
      logic cmp_b_out;
   } timer0_t;

endpackage : pin_alt_pkg

// ==== design/pin_ovr_cell.sv ====
`timescale 1ns/1ps

module pin_ovr_cell (
   input  wire  pin_alt_pkg::ovr_t     ovr_i,
   input  wire  pin_alt_pkg::pin_cfg_t cfg_i,
   input  wire  logic                  pud_i,
   input  wire  logic                  sleep_i,
   input  wire  logic                  pad_i,
   output pin_alt_pkg::pad_ctl_t       pad_o,
   output logic                        digin_o
);
   import pin_alt_pkg::*;

   wire drive_en;
   wire in_en;

   assign pad_o.pullup_en = ovr_i.pullup_ovr_en ? ovr_i.pullup_ovr_val
                          : (!cfg_i.dir && cfg_i.out && !pud_i);
   assign drive_en        = ovr_i.dir_ovr_en ? ovr_i.dir_ovr_val : cfg_i.dir;
   assign pad_o.drive_n   = !drive_en;
   assign pad_o.drive_val = ovr_i.outval_ovr_en ? ovr_i.outval_ovr_val : cfg_i.out;
   // Clamp input in sleep unless an alternate function needs it
   assign in_en           = ovr_i.digin_ovr_en ? ovr_i.digin_ovr_val : !sleep_i;
   assign digin_o         = pad_i & in_en;

endmodule : pin_ovr_cell

// ==== sim/pin_alt_properties.sv ====
`timescale 1ns/1ps
module pin_alt_checker
   import pin_alt_pkg::*;
(
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic [31:0]                 wb_dat_o,
   input wire logic                        wb_ack_o,
   input wire pin_alt_pkg::spi_t           spi_i,
   input wire logic [7:0]                  pad_a_i,
   input wire logic [7:2]                  pad_b_i,
   input wire pin_alt_pkg::pad_ctl_t [7:2] pad_b_o,
   input wire logic [7:0]                  adc_ch_o,
   input wire logic                        comparator_neg_in_o,
   input wire logic                        comparator_pos_in_o,
   input wire logic [15:10]                pin_change_src_high_o,
   input wire logic                        ext_irq_two_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   logic slave;
   logic mst;
   assign slave = spi_i.en & ~spi_i.master;
   assign mst   = spi_i.en & spi_i.master;
   ////////////////////////////////////////
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   adc_pass_a: assert property (adc_ch_o == pad_a_i)
      else $error("converter channel mismatch");
   cmp_direct_a: assert property ({comparator_neg_in_o, comparator_pos_in_o} == pad_b_i[3:2])
      else $error("comparator input mismatch");
   sck_slave_a: assert property (slave |-> pad_b_o[7].drive_n)
      else $error("clock pin driven as slave");
   sck_value_a: assert property (mst && !pad_b_o[7].drive_n |-> pad_b_o[7].drive_val == spi_i.sck_out)
      else $error("clock pin value wrong");
   miso_master_a: assert property (mst |-> pad_b_o[6].drive_n)
      else $error("master input pin driven");
   mosi_slave_a: assert property (slave |-> pad_b_o[5].drive_n)
      else $error("slave input pin driven");
   ss_slave_a: assert property (slave |-> pad_b_o[4].drive_n)
      else $error("select pin driven as slave");
   int_two_a: assert property (ext_irq_two_o == pin_change_src_high_o[10])
      else $error("interrupt two input mismatch");
endmodule : pin_alt_checker

bind port_ab_alt_function_override pin_alt_checker props (.*);

// ==== sim/pad_partner.sv ====
`timescale 1ns/1ps
module pad_partner
   import pin_alt_pkg::*;
(
   input  wire pin_alt_pkg::pad_ctl_t [7:0] drv_a_i,
   input  wire pin_alt_pkg::pad_ctl_t [7:2] drv_b_i,
   input  wire logic [7:0]                  ext_a_i,
   input  wire logic [7:2]                  ext_b_i,
   output logic [7:0]                       level_a_o,
   output logic [7:2]                       level_b_o
);
   // Chip driver beats the board, pull-up beats a floating board line
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level_a_o[i] = !drv_a_i[i].drive_n ? drv_a_i[i].drive_val : (drv_a_i[i].pullup_en | ext_a_i[i]);
      end
      for (int i = 2; i < 8; i++) begin
         level_b_o[i] = !drv_b_i[i].drive_n ? drv_b_i[i].drive_val : (drv_b_i[i].pullup_en | ext_b_i[i]);
      end
   end
endmodule : pad_partner

// ==== sim/port_ab_alt_function_override_test.sv ====
`timescale 1ns/1ps
`include "pin_alt_defines.svh"
module port_ab_alt_function_override_test;
   import pin_alt_pkg::*;
   logic           clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, ext_irq_two_en_i, wb_ack_o, irq_o;
   logic           comparator_neg_in_o, comparator_pos_in_o, ext_irq_two_o;
   logic           spi_sck_in_o, spi_master_in_o, spi_slave_in_o, spi_ss_n_o;
   logic [3:0]     wb_sel_i;
   logic [7:0]     wb_adr_i, pad_a_i, adc_ch_o, pin_change_src_low_o, ext_a, g, d, o, m, s;
   logic [2:0]     c;
   logic [31:0]    wb_dat_i, wb_dat_o, rdat;
   logic [7:2]     pad_b_i, ext_b, en;
   logic [15:10]   pin_change_src_high_o;
   logic [17:0]    e;
   spi_t           spi_i;
   timer0_t        timer0_i;
   pad_ctl_t [7:0] pad_a_o, pbx;
   pad_ctl_t [7:2] pad_b_o;
   int             errors, comparisons, cycles;

   port_ab_alt_function_override DUT (.*);
   pad_partner far (.drv_a_i(pad_a_o), .drv_b_i(pad_b_o), .ext_a_i(ext_a), .ext_b_i(ext_b),
                    .level_a_o(pad_a_i), .level_b_o(pad_b_i));
   assign pbx = {pad_b_o, 6'h00};
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
      comparisons++;
      if (y !== x) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, x, y);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= v;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic final_report();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   function automatic logic [7:0] fld(input pad_ctl_t [7:0] p, input int k);
      for (int i = 0; i < 8; i++) fld[i] = p[i][k];
   endfunction : fld

   // Returns {drive_n, value, pull-up} for pins 7:2
   function automatic logic [17:0] pb_exp(input logic [7:0] dr, ou, input logic global_pullup_disable, input spi_t sp,
                                          input timer0_t t);
      logic       sl, ms;
      logic [7:2] f, v;
      sl = sp.en & ~sp.master;
      ms = sp.en & sp.master;
      f = {sl, ms, sl, sl, 2'b00};
      v = ou[7:2];
      if (ms) v[7] = sp.sck_out;
      if (sl) v[6] = sp.slave_out;
      if (ms) v[5] = sp.mstr_out;
      if (t.cmp_b_en) v[4] = t.cmp_b_out;
      if (t.cmp_a_en) v[3] = t.cmp_a_out;
      return {~(dr[7:2] & ~f), v, (f | ~dr[7:2]) & ou[7:2] & {6{~global_pullup_disable}}};
   endfunction : pb_exp
   ////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         final_report();
      end
   end

   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, ext_irq_two_en_i} = 6'h20;
      {wb_adr_i, wb_dat_i, ext_a, ext_b, spi_i, timer0_i} = '0;
      wb_sel_i = 4'hF;
      void'($urandom(33));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // Whole map plus two unmapped words
      for (int a = 0; a < 14; a++) begin
         wb(1'b0, 8'(a * 4), 32'h0);
         chk("reset_read", 32'h0, rdat);
      end
      chk("reset_drive_n", 32'h0000_00FF, 32'(fld(pad_a_o, 2)));
      wb(1'b1, 8'h34, 32'h0000_00FF);
      wb(1'b0, 8'h34, 32'h0);
      chk("unmapped_read", 32'h0, rdat);
      wb(1'b1, `OFS_CTRL, 32'h1);
      wb(1'b1, `OFS_PC_MASK_A, 32'h1);
      wb(1'b1, `OFS_IRQ_MASK, 32'h1);
      @(posedge clk_i);
      ext_a <= 8'h01;
      repeat (3) @(posedge clk_i);
      wb(1'b0, `OFS_IRQ_STAT, 32'h0);
      chk("irq_status", 32'h1, rdat);
      chk("irq_level", 32'h1, 32'(irq_o));
      wb(1'b1, `OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("irq_masked", 32'h0, 32'(irq_o));
      wb(1'b1, `OFS_IRQ_MASK, 32'h1);
      wb(1'b1, `OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk_i);
      chk("irq_cleared", 32'h0, 32'(irq_o));
      wb(1'b0, `OFS_IRQ_STAT, 32'h0);
      chk("irq_status", 32'h0, rdat);
      for (int n = 0; n < 16; n++) begin
         {d, o, m, s, c} = {$urandom, 3'($urandom)};
         wb(1'b1, `OFS_PA_DIR, {24'h0, d});
         wb(1'b1, `OFS_PA_OUT, {24'h0, o});
         wb(1'b1, `OFS_PC_MASK_A, {24'h0, m});
         wb(1'b1, `OFS_ADC_DIDIS, {24'h0, s});
         wb(1'b1, `OFS_CTRL, {29'h0, c});
         @(posedge clk_i);
         ext_a <= 8'($urandom);
         sleep_i <= 1'($urandom);
         @(negedge clk_i);
         // Same cycle as the input change: no register in the path
         chk("pa_drive_n", 32'(8'(~d)), 32'(fld(pad_a_o, 2)));
         chk("pa_value", 32'(d & o), 32'(d & fld(pad_a_o, 1)));
         chk("pa_pullup", 32'(~d & o & {8{~c[2]}}), 32'(fld(pad_a_o, 0)));
         chk("pa_pin_change", 32'(pad_a_i & ((m & {8{c[0]}}) | (~s & {8{~sleep_i}}))),
             32'(pin_change_src_low_o));
      end
      for (int n = 0; n < 24; n++) begin
         {d, o, m, s, c} = {$urandom, 3'($urandom)};
         wb(1'b1, `OFS_PB_DIR, {24'h0, d});
         wb(1'b1, `OFS_PB_OUT, {24'h0, o});
         wb(1'b1, `OFS_PC_MASK_B, {24'h0, m});
         wb(1'b1, `OFS_CTRL, {29'h0, c});
         @(posedge clk_i);
         spi_i <= {n % 3 != 0, n % 3 == 1, 3'($urandom)};
         timer0_i <= 4'($urandom);
         ext_b <= 6'($urandom);
         sleep_i <= 1'($urandom);
         ext_irq_two_en_i <= 1'($urandom);
         @(negedge clk_i);
         e = pb_exp(d, o, c[2], spi_i, timer0_i);
         en = (m[7:2] & {6{c[1]}}) | {6{~sleep_i}} | {5'h00, ext_irq_two_en_i};
         g = fld(pbx, 2);
         chk("pb_drive_n", 32'(e[17:12]), 32'(g[7:2]));
         g = fld(pbx, 1);
         chk("pb_value", 32'(e[11:6] & ~e[17:12]), 32'(g[7:2] & ~e[17:12]));
         g = fld(pbx, 0);
         chk("pb_pullup", 32'(e[5:0]), 32'(g[7:2]));
         chk("pb_pin_change", 32'(pad_b_i & en), 32'(pin_change_src_high_o));
         chk("spi_inputs", 32'(pad_b_i[7:4] & en[7:4]),
             32'({spi_sck_in_o, spi_master_in_o, spi_slave_in_o, spi_ss_n_o}));
         chk("ext_irq_two", 32'(pad_b_i[2] & en[2]), 32'(ext_irq_two_o));
      end
      final_report();
   end
endmodule : port_ab_alt_function_override_test
